// >>> dmc_top.sv
// Four-channel DMA register block and transfer engine with an Avalon-MM slave.
// Assumes one 10 MHz clock, async active-high reset, and a transfer-side bus
// that answers each command with a one-cycle xfer_ack.
//
// Overview of operation
// (RULE1) Address counters and reloads keep 24 bits; upper 8 bits read zero.
// (RULE2) Direction 0: A is source, fly-by reads; 1: A destination, fly-by writes.
// (RULE3) A address steps after each cycle when enabled: +1, +2, -1, -2.
// (RULE4) B address steps likewise after each cycle, only when its enable is set.
// (RULE5) Fly-by transfers never use or reload the B counter or reload.
// (RULE6) Length counter drops by one per transfer cycle, byte or word.
// (RULE7) A zero length, counter or reload, means 65535 transfer cycles.
// (RULE8) Writing the length reload sets next-valid; write it last.
// (RULE9) Control word clears at reset; its reserved bit 15 stays zero.
// (RULE10) Writing enable 1 always arms a transfer; all enables clear gates clock. Code arms only while the length counter is non-zero.
// (RULE11) Interrupt when terminal count or overrun flag set with its enable.
// (RULE12) Cycle size 0 is byte, 1 is word; software matches fly-by width.
// (RULE13) Transfer type 0 is fly-by, 1 is memory-to-memory.
// (RULE14) Operation type 0 is single/double buffer, 1 is auto-initialize.
// (RULE15) Bus policy 0 releases bus per transaction; 1 holds while requested. Code releases per transfer cycle, across both memory-to-memory transactions.
// (RULE16) Software uses burst policy only with software requests.
// (RULE17) Software request bit 1 asserts, 0 withdraws; written while inactive.
// (RULE18) Status: TC bit0, OVERRUN_FLAG bit1, active bit2, valid bit3; write-1 clears.
// (RULE19) Terminal count flag sets when length counter reaches zero.
// (RULE20) Buffer mode: overrun sets at block end with next-valid clear.
// (RULE21) Auto mode: overrun sets at block end with terminal count still set.
// (RULE22) Channel active is read-only: enable set and length non-zero.
// (RULE23) Buffer mode block end: reload and continue if valid, else stop.
// (RULE24) Auto mode reloads and repeats every block until enable cleared.
// (RULE25) Debug halt suspends all channels; they resume where they stopped.
// (RULE26) Copying reloads clears next-valid; B copies only in memory-to-memory.
// (RULE27) Channel interrupt is a level while any enabled sticky flag is set.
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "dmc_defs.svh"

module dmc_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Transfer side
    input wire logic [3:0] hw_request_line,
    input wire logic debug_freeze,
    output dmc_pkg::dmc_xfer_s xfer_cmd,
    output logic xfer_valid,
    input wire logic xfer_ack,
    input wire logic [15:0] xfer_rdata,
    output logic bus_hold,
    // Channel status
    output logic [3:0] channel_irq,
    output logic clock_gate_en
);

    // Channel registers
    logic [23:0] a_cnt_reg [0:3];
    logic [23:0] a_rel_reg [0:3];
    logic [23:0] b_cnt_reg [0:3];
    logic [23:0] b_rel_reg [0:3];
    logic [15:0] len_cnt_reg [0:3];
    logic [15:0] len_rel_reg [0:3];
    dmc_pkg::dmc_ctrl_s ctrl_reg [0:3];
    logic [3:0] tc_reg;
    logic [3:0] ovr_reg;
    logic [3:0] vld_reg;

    // Bus slave
    logic waitreq_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rd_mux;
    logic [31:0] wr_val;
    logic wr_take;
    logic unmapped;
    logic [1:0] acc_ch;
    logic [2:0] acc_idx;

    // Engine
    dmc_pkg::dmc_eng_e eng_reg;
    logic [1:0] cur_reg;
    dmc_pkg::dmc_xfer_s cmd_reg;
    logic valid_reg;
    logic hold_reg;
    dmc_pkg::dmc_xfer_s first_cmd;
    logic [1:0] sel_ch;
    logic step_pulse;
    logic last_cycle;
    logic [23:0] a_step_nxt;
    logic [23:0] b_step_nxt;
    logic [1:0] gnt_idx;
    logic gnt_any;

    // Per-channel derived state
    logic [3:0] channel_active;
    logic [3:0] req;
    logic [3:0] irq_next;
    logic [3:0] channel_enable_bit_vec;
    logic [3:0] irq_reg;
    logic gate_reg;

    function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // Zero stands for the longest block, so it is widened on load
    function automatic logic [15:0] len_fix(input logic [15:0] v);
        return (v == `DMC_LEN_ZERO) ? `DMC_LEN_MAX : v; // [RULE7]
    endfunction : len_fix

    assign unmapped = avs_address[`DMC_ADDR_UNMAP_BIT];
    assign acc_ch = avs_address[`DMC_ADDR_CH_MSB:`DMC_ADDR_CH_LSB];
    assign acc_idx = avs_address[`DMC_ADDR_REG_MSB:`DMC_ADDR_REG_LSB];
    assign wr_take = avs_write && !waitreq_reg && !unmapped;
    assign wr_val = be_merge(rd_mux, avs_writedata, avs_byteenable);

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            channel_enable_bit_vec[i] = ctrl_reg[i].channel_enable_bit;
            channel_active[i] = ctrl_reg[i].channel_enable_bit && (len_cnt_reg[i] != `DMC_LEN_ZERO); // [RULE22]
            req[i] = channel_active[i] && (hw_request_line[i] || ctrl_reg[i].software_request); // [RULE17]
            irq_next[i] = (tc_reg[i] && ctrl_reg[i].terminal_count_irq_en)
                || (ovr_reg[i] && ctrl_reg[i].overrun_irq_en); // [RULE11] [RULE27]
        end
    end

    // Readback; counters read back with the upper byte zero
    always_comb begin
        rd_mux = '0;
        if (!unmapped) begin
            unique case (acc_idx)
                `DMC_REG_A_CNT: rd_mux = {`DMC_TOP_PAD, a_cnt_reg[acc_ch]}; // [RULE1]
                `DMC_REG_A_REL: rd_mux = {`DMC_TOP_PAD, a_rel_reg[acc_ch]};
                `DMC_REG_B_CNT: rd_mux = {`DMC_TOP_PAD, b_cnt_reg[acc_ch]};
                `DMC_REG_B_REL: rd_mux = {`DMC_TOP_PAD, b_rel_reg[acc_ch]};
                `DMC_REG_LEN_CNT: rd_mux = {`DMC_HALF_PAD, len_cnt_reg[acc_ch]};
                `DMC_REG_LEN_REL: rd_mux = {`DMC_HALF_PAD, len_rel_reg[acc_ch]};
                `DMC_REG_CTRL: rd_mux = {`DMC_HALF_PAD, 16'(ctrl_reg[acc_ch])};
                `DMC_REG_STAT: rd_mux = {`DMC_HALF_PAD, `DMC_TOP_PAD, `DMC_STAT_PAD, vld_reg[acc_ch],
                    channel_active[acc_ch], ovr_reg[acc_ch], tc_reg[acc_ch]}; // [RULE18]
            endcase
        end
    end

    // Every access waits exactly one cycle; data is captured as wait drops
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            waitreq_reg <= 1'b1;
            rdata_reg <= '0;
        end else if ((avs_read || avs_write) && waitreq_reg) begin
            waitreq_reg <= 1'b0;
            rdata_reg <= avs_read ? rd_mux : '0;
        end else begin
            waitreq_reg <= 1'b1;
        end
    end

    // Arbiter and address steppers for the channel under service
    dmc_arb #(.N(4), .IW(2)) u_arb (
        .req(req),
        .gnt_idx(gnt_idx),
        .any(gnt_any)
    );

    dmc_step u_step_a (
        .addr(a_cnt_reg[cur_reg]),
        .enable(ctrl_reg[cur_reg].a_step_enable),
        .code(ctrl_reg[cur_reg].a_step_code),
        .addr_next(a_step_nxt)
    ); // [RULE3]

    dmc_step u_step_b (
        .addr(b_cnt_reg[cur_reg]),
        .enable(ctrl_reg[cur_reg].b_step_enable),
        .code(ctrl_reg[cur_reg].b_step_code),
        .addr_next(b_step_nxt)
    ); // [RULE4]

    assign step_pulse = (eng_reg == dmc_pkg::DMC_ENG_STEP) && !debug_freeze; // [RULE25]
    assign last_cycle = len_cnt_reg[cur_reg] == `DMC_LEN_ONE;

    // First transaction of a transfer cycle for the channel about to run
    always_comb begin
        sel_ch = (eng_reg == dmc_pkg::DMC_ENG_IDLE) ? gnt_idx : cur_reg;
        first_cmd.chan = sel_ch;
        first_cmd.word = ctrl_reg[sel_ch].cycle_size_sel; // [RULE12]
        first_cmd.wdata = '0;
        if (ctrl_reg[sel_ch].memory_to_memory_sel) begin // [RULE13]
            first_cmd.addr = ctrl_reg[sel_ch].direction ? b_cnt_reg[sel_ch] : a_cnt_reg[sel_ch]; // [RULE2]
            first_cmd.write = 1'b0;
            first_cmd.flyby = 1'b0;
        end else begin
            first_cmd.addr = a_cnt_reg[sel_ch]; // [RULE5]
            first_cmd.write = ctrl_reg[sel_ch].direction; // [RULE2]
            first_cmd.flyby = 1'b1;
        end
    end

    // Transfer engine
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            eng_reg <= dmc_pkg::DMC_ENG_IDLE;
            cur_reg <= '0;
            cmd_reg <= '0;
            valid_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            unique case (eng_reg)
                dmc_pkg::DMC_ENG_IDLE: begin
                    if (gnt_any && !debug_freeze) begin // [RULE25]
                        cur_reg <= gnt_idx;
                        cmd_reg <= first_cmd;
                        valid_reg <= 1'b1;
                        hold_reg <= 1'b1;
                        eng_reg <= dmc_pkg::DMC_ENG_SRC;
                    end
                end
                dmc_pkg::DMC_ENG_SRC: begin
                    if (xfer_ack) begin
                        if (ctrl_reg[cur_reg].memory_to_memory_sel) begin
                            cmd_reg.addr <= ctrl_reg[cur_reg].direction ? a_cnt_reg[cur_reg]
                                : b_cnt_reg[cur_reg]; // [RULE2]
                            cmd_reg.write <= 1'b1;
                            cmd_reg.wdata <= xfer_rdata;
                            eng_reg <= dmc_pkg::DMC_ENG_DST;
                        end else begin
                            valid_reg <= 1'b0;
                            eng_reg <= dmc_pkg::DMC_ENG_STEP;
                        end
                    end
                end
                dmc_pkg::DMC_ENG_DST: begin
                    if (xfer_ack) begin
                        valid_reg <= 1'b0;
                        eng_reg <= dmc_pkg::DMC_ENG_STEP;
                    end
                end
                dmc_pkg::DMC_ENG_STEP: begin
                    if (!debug_freeze) begin
                        if (ctrl_reg[cur_reg].burst_policy_sel) begin // [RULE15]
                            eng_reg <= dmc_pkg::DMC_ENG_HOLD;
                        end else begin
                            hold_reg <= 1'b0; // [RULE15]
                            eng_reg <= dmc_pkg::DMC_ENG_IDLE;
                        end
                    end
                end
                dmc_pkg::DMC_ENG_HOLD: begin
                    // Counters are already stepped here, so the next address is fresh
                    if (!req[cur_reg]) begin
                        hold_reg <= 1'b0;
                        eng_reg <= dmc_pkg::DMC_ENG_IDLE;
                    end else if (!debug_freeze) begin
                        cmd_reg <= first_cmd;
                        valid_reg <= 1'b1;
                        eng_reg <= dmc_pkg::DMC_ENG_SRC;
                    end
                end
            endcase
        end
    end

    // Channel registers: sticky clears first, engine next, software writes last
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                a_cnt_reg[i] <= `DMC_ADDR_RST;
                a_rel_reg[i] <= `DMC_ADDR_RST;
                b_cnt_reg[i] <= `DMC_ADDR_RST;
                b_rel_reg[i] <= `DMC_ADDR_RST;
                len_cnt_reg[i] <= `DMC_LEN_RST;
                len_rel_reg[i] <= `DMC_LEN_RST;
                ctrl_reg[i] <= dmc_pkg::dmc_ctrl_s'(`DMC_CTRL_RST); // [RULE9]
            end
            tc_reg <= '0;
            ovr_reg <= '0;
            vld_reg <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_take && acc_ch == 2'(i) && acc_idx == `DMC_REG_STAT && avs_byteenable[0]) begin
                    if (avs_writedata[`DMC_ST_TC]) tc_reg[i] <= 1'b0; // [RULE18]
                    if (avs_writedata[`DMC_ST_OVR]) ovr_reg[i] <= 1'b0; // [RULE18]
                    if (avs_writedata[`DMC_ST_VLD]) vld_reg[i] <= 1'b0; // [RULE18]
                end
                if (step_pulse && cur_reg == 2'(i)) begin
                    // Last cycle steps too; a reload below overrides the step
                    a_cnt_reg[i] <= a_step_nxt; // [RULE3]
                    if (ctrl_reg[i].memory_to_memory_sel) b_cnt_reg[i] <= b_step_nxt; // [RULE4] [RULE5]
                    len_cnt_reg[i] <= len_cnt_reg[i] - `DMC_LEN_ONE; // [RULE6] [RULE23]
                    if (last_cycle) begin
                        tc_reg[i] <= 1'b1; // [RULE19]
                        if (ctrl_reg[i].auto_reload_sel ? tc_reg[i] : !vld_reg[i]) begin // [RULE14]
                            ovr_reg[i] <= 1'b1; // [RULE20] [RULE21]
                        end
                        if (ctrl_reg[i].auto_reload_sel || vld_reg[i]) begin // [RULE23] [RULE24]
                            a_cnt_reg[i] <= a_rel_reg[i];
                            if (ctrl_reg[i].memory_to_memory_sel) b_cnt_reg[i] <= b_rel_reg[i]; // [RULE26]
                            len_cnt_reg[i] <= len_fix(len_rel_reg[i]);
                            vld_reg[i] <= 1'b0; // [RULE26]
                        end
                    end
                end
                if (wr_take && acc_ch == 2'(i)) begin
                    unique case (acc_idx)
                        `DMC_REG_A_CNT: a_cnt_reg[i] <= wr_val[23:0]; // [RULE1]
                        `DMC_REG_A_REL: a_rel_reg[i] <= wr_val[23:0];
                        `DMC_REG_B_CNT: b_cnt_reg[i] <= wr_val[23:0];
                        `DMC_REG_B_REL: b_rel_reg[i] <= wr_val[23:0];
                        `DMC_REG_LEN_CNT: len_cnt_reg[i] <= len_fix(wr_val[15:0]); // [RULE7]
                        `DMC_REG_LEN_REL: begin
                            len_rel_reg[i] <= wr_val[15:0];
                            vld_reg[i] <= 1'b1; // [RULE8]
                        end
                        // Enable written as 1 simply re-arms; any non-zero count runs
                        `DMC_REG_CTRL: ctrl_reg[i] <= dmc_pkg::dmc_ctrl_s'(wr_val[15:0]
                            & `DMC_CTRL_MASK); // [RULE9] [RULE10] [RULE14]
                        `DMC_REG_STAT: begin
                        end
                    endcase
                end
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_reg <= '0;
            gate_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next; // [RULE27]
            gate_reg <= |channel_enable_bit_vec; // [RULE10]
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = waitreq_reg;
    assign xfer_cmd = cmd_reg;
    assign xfer_valid = valid_reg;
    assign bus_hold = hold_reg;
    assign channel_irq = irq_reg;
    assign clock_gate_en = gate_reg;

endmodule : dmc_top
`default_nettype wire

// >>> dmc_defs.svh
// Constants for the four-channel DMA register block: offsets, field positions,
// reset values and step codes. Included by the dmc_top and dmc_step modules.
`ifndef DMC_DEFS_SVH
`define DMC_DEFS_SVH

// Byte address layout: bit 7 unmapped, bits 6:5 channel, bits 4:2 register
`define DMC_ADDR_W 8
`define DMC_ADDR_UNMAP_BIT 7
`define DMC_ADDR_CH_MSB 6
`define DMC_ADDR_CH_LSB 5
`define DMC_ADDR_REG_MSB 4
`define DMC_ADDR_REG_LSB 2

// Register index within a channel (byte offset = 4 * index)
`define DMC_REG_A_CNT 3'h0
`define DMC_REG_A_REL 3'h1
`define DMC_REG_B_CNT 3'h2
`define DMC_REG_B_REL 3'h3
`define DMC_REG_LEN_CNT 3'h4
`define DMC_REG_LEN_REL 3'h5
`define DMC_REG_CTRL 3'h6
`define DMC_REG_STAT 3'h7

// Status bit positions
`define DMC_ST_TC 0
`define DMC_ST_OVR 1
`define DMC_ST_ACT 2
`define DMC_ST_VLD 3

// Widths and reset values
`define DMC_ADDR_BITS 24
`define DMC_ADDR_RST 24'h000000
`define DMC_LEN_RST 16'h0000
`define DMC_CTRL_RST 16'h0000
`define DMC_CTRL_MASK 16'h7fff
`define DMC_LEN_ZERO 16'h0000
`define DMC_LEN_ONE 16'h0001
`define DMC_LEN_MAX 16'hffff
`define DMC_STAT_PAD 4'h0
`define DMC_TOP_PAD 8'h00
`define DMC_HALF_PAD 16'h0000

// Address step codes and deltas
`define DMC_STEP_INC1 2'h0
`define DMC_STEP_INC2 2'h1
`define DMC_STEP_DEC1 2'h2
`define DMC_STEP_DEC2 2'h3
`define DMC_DELTA_ONE 24'h000001
`define DMC_DELTA_TWO 24'h000002

`endif

// >>> dmc_pkg.sv
// Types shared by the DMA register block: control word layout, transfer
// command carrier and engine states. Constants live in dmc_defs.svh.
package dmc_pkg;

    // Control word, bit 15 down to bit 0
    typedef struct packed {
        logic reserved;
        logic [1:0] b_step_code;
        logic b_step_enable;
        logic [1:0] a_step_code;
        logic a_step_enable;
        logic software_request;
        logic burst_policy_sel;
        logic auto_reload_sel;
        logic direction;
        logic memory_to_memory_sel;
        logic cycle_size_sel;
        logic overrun_irq_en;
        logic terminal_count_irq_en;
        logic channel_enable_bit;
    } dmc_ctrl_s;

    // One transaction on the transfer side
    typedef struct packed {
        logic [1:0] chan;
        logic [23:0] addr;
        logic write;
        logic word;
        logic flyby;
        logic [15:0] wdata;
    } dmc_xfer_s;

    typedef enum logic [4:0] {
        DMC_ENG_IDLE = 5'b00001,
        DMC_ENG_SRC = 5'b00010,
        DMC_ENG_DST = 5'b00100,
        DMC_ENG_STEP = 5'b01000,
        DMC_ENG_HOLD = 5'b10000
    } dmc_eng_e;

endpackage : dmc_pkg

// >>> dmc_step.sv
// Address stepper: next counter value from the enable and two-bit step code.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none
`include "dmc_defs.svh"

module dmc_step (
    // Current address and step control
    input wire logic [23:0] addr,
    input wire logic enable,
    input wire logic [1:0] code,
    // Stepped address
    output logic [23:0] addr_next
);

    always_comb begin
        addr_next = addr;
        if (enable) begin
            unique case (code)
                `DMC_STEP_INC1: addr_next = addr + `DMC_DELTA_ONE;
                `DMC_STEP_INC2: addr_next = addr + `DMC_DELTA_TWO;
                `DMC_STEP_DEC1: addr_next = addr - `DMC_DELTA_ONE;
                `DMC_STEP_DEC2: addr_next = addr - `DMC_DELTA_TWO;
            endcase
        end
    end

endmodule : dmc_step
`default_nettype wire

// >>> dmc_arb.sv
// Fixed-priority request picker; the lowest channel number wins.
// Combinational; the engine takes the grant only when idle.
`timescale 1ns/100ps
`default_nettype none

module dmc_arb #(
    parameter int N = 4,
    parameter int IW = 2
) (
    // Requests
    input wire logic [N-1:0] req,
    // Grant
    output logic [IW-1:0] gnt_idx,
    output logic any
);

    always_comb begin
        gnt_idx = '0;
        any = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                gnt_idx = IW'(i);
                any = 1'b1;
            end
        end
    end

endmodule : dmc_arb
`default_nettype wire

// >>> dmc_asserts.sv
// Port-level checker for dmc_top, attached by bind.
// Assumes readdata is valid in the cycle waitrequest is low.
`timescale 1ns/100ps
`default_nettype none
module dmc_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Transfer side
    input wire logic debug_freeze,
    input wire dmc_pkg::dmc_xfer_s xfer_cmd,
    input wire logic xfer_valid,
    input wire logic xfer_ack,
    input wire logic bus_hold,
    input wire logic clock_gate_en
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic rdone;
    assign rdone = avs_read && !avs_waitrequest && !avs_address[7];
    a_addr_top: assert property (rdone && avs_address[4:2] < 3'h4 |-> avs_readdata[31:24] == 8'h00)
        else $error("address top byte not zero");
    a_half_top: assert property (rdone && avs_address[4:2] inside {3'h4, 3'h5, 3'h6}
        |-> avs_readdata[31:16] == 16'h0000)
        else $error("16-bit register upper half not zero");
    a_stat_pad: assert property (rdone && avs_address[4:2] == 3'h7 |-> avs_readdata[31:4] == 28'h0)
        else $error("status reserved bits not zero");
    a_ctrl_resv: assert property (rdone && avs_address[4:2] == 3'h6 |-> !avs_readdata[15])
        else $error("control reserved bit set");
    a_freeze_start: assert property (debug_freeze && !xfer_valid |=> !xfer_valid)
        else $error("transfer started while frozen");
    a_cmd_hold: assert property (xfer_valid && !xfer_ack |=> xfer_valid && $stable(xfer_cmd))
        else $error("command changed before ack");
    a_bus_owned: assert property (xfer_valid |-> bus_hold)
        else $error("transfer without bus ownership");
    a_gate_on: assert property ($rose(xfer_valid) |-> clock_gate_en)
        else $error("transfer with clock gated");
endmodule : dmc_asserts
bind dmc_top dmc_asserts u_dmc_asserts (.clock, .rst, .avs_address, .avs_read, .avs_readdata,
    .avs_waitrequest, .debug_freeze, .xfer_cmd, .xfer_valid, .xfer_ack, .bus_hold, .clock_gate_en);
`default_nettype wire

// >>> dmc_bus_model.sv
// Transfer-side bus: acks each command after 1 or 4 cycles, logs the last.
// Read data is only meaningful with the ack; it toggles otherwise.
`timescale 1ns/100ps
`default_nettype none
module dmc_bus_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Command side
    input wire logic xfer_valid,
    input wire dmc_pkg::dmc_xfer_s xfer_cmd,
    input wire logic slow,
    output logic xfer_ack,
    output logic [15:0] xfer_rdata,
    // Log
    output logic [31:0] n_ack,
    output dmc_pkg::dmc_xfer_s last_cmd
);
    logic [1:0] cnt;
    logic ack_n;
    assign ack_n = xfer_valid && !xfer_ack && cnt == (slow ? 2'h3 : 2'h0);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt <= 2'h0;
            xfer_ack <= 1'b0;
            xfer_rdata <= 16'h0000;
            n_ack <= 32'h0;
            last_cmd <= '0;
        end else begin
            cnt <= (xfer_valid && !xfer_ack && !ack_n) ? cnt + 2'h1 : 2'h0;
            xfer_ack <= ack_n;
            // No hold time: stale data is inverted so it cannot pass
            xfer_rdata <= ack_n ? {8'h5a, xfer_cmd.addr[7:0]} : ~xfer_rdata;
            if (xfer_valid && xfer_ack) begin
                n_ack <= n_ack + 32'h1;
                last_cmd <= xfer_cmd;
            end
        end
    end
endmodule : dmc_bus_model
`default_nettype wire

// >>> tb_top.sv
// Register-level bench for dmc_top with the bus model on the transfer side.
// Assumes Avalon answers in bounded time; the watchdog ends any hang.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clock = 0, rst = 1, avs_read = 0, avs_write = 0, debug_freeze = 0, slow = 0;
    logic [7:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, n_ack, rd, nb;
    logic [3:0] avs_byteenable = 4'hf, hw_request_line = 0, channel_irq;
    logic avs_waitrequest, xfer_valid, xfer_ack, bus_hold, clock_gate_en;
    logic [15:0] xfer_rdata;
    dmc_pkg::dmc_xfer_s xfer_cmd, last_cmd;
    int fail_count = 0, num_checks = 0;
    always #50 clock = ~clock;
    dmc_top u_dmc_top (.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .hw_request_line, .debug_freeze, .xfer_cmd, .xfer_valid, .xfer_ack,
        .xfer_rdata, .bus_hold, .channel_irq, .clock_gate_en);
    dmc_bus_model u_dmc_bus_model (.clock, .rst, .xfer_valid, .xfer_cmd, .slow, .xfer_ack, .xfer_rdata,
        .n_ack, .last_cmd);
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
    endtask : acc
    task wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask : wr
    task rchk(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rchk
    task waitack(input logic [31:0] n);
        for (int i = 0; i < 300 && n_ack < n; i++) @(negedge clock);
        @(posedge clock);
    endtask : waitack
    // Status cleared before control, so enabling comes last
    task prog(input logic [7:0] b, input logic [15:0] ctl, input logic [15:0] len);
        wr(b, 32'h100);
        wr(b + 8'h08, 32'h200);
        wr(b + 8'h10, {16'h0, len});
        wr(b + 8'h1c, 32'hf);
        wr(b + 8'h18, {16'h0, ctl});
    endtask : prog
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clock);
        rst <= 0;
        rchk(8'h18, 32'h0);
        rchk(8'h1c, 32'h0);
        wr(8'h80, 32'hffffffff);
        rchk(8'h80, 32'h0);
        wr(8'h20, 32'hffffffff);
        rchk(8'h20, 32'h00ffffff);
        wr(8'h38, 32'hffffffff);
        rchk(8'h38, 32'h7fff);
        wr(8'h38, 32'h0);
        wr(8'h30, 32'h0);
        rchk(8'h30, 32'hffff);
        wr(8'h34, 32'h5);
        rchk(8'h3c, 32'h8);
        wr(8'h3c, 32'h4);
        rchk(8'h3c, 32'h8);
        wr(8'h3c, 32'h8);
        rchk(8'h3c, 32'h0);
        $display("register test done");
        for (int c = 0; c < 4; c++) begin
            prog(8'h00, 16'h122b | 16'(c << 10) | 16'(c << 13), 16'h1);
            nb = n_ack;
            hw_request_line[0] <= 1'b1;
            waitack(nb + 1);
            hw_request_line[0] <= 1'b0;
            chk(last_cmd.write, 1'b1);
            chk(last_cmd.flyby, 1'b1);
            chk(last_cmd.word, 1'b1);
            rchk(8'h00, c[1] ? 32'h100 - (c[0] + 1) : 32'h100 + (c[0] + 1));
            rchk(8'h08, 32'h200);
            rchk(8'h10, 32'h0);
            rchk(8'h1c, 32'h3);
            chk(channel_irq, 4'h1);
            chk(bus_hold, 1'b0);
        end
        wr(8'h1c, 32'h1);
        repeat (2) @(posedge clock);
        chk(channel_irq, 4'h0);
        $display("fly-by test done");
        slow <= 1'b1;
        nb = n_ack;
        prog(8'h40, 16'h7391, 16'h1);
        waitack(nb + 2);
        chk(last_cmd.addr, 32'h200);
        chk(last_cmd.wdata, 32'h5a00);
        rchk(8'h40, 32'h101);
        rchk(8'h48, 32'h1fe);
        wr(8'h58, 32'h0);
        $display("memory test done");
        prog(8'h60, 16'h0047, 16'h1);
        wr(8'h64, 32'h300);
        wr(8'h74, 32'h1);
        nb = n_ack;
        debug_freeze <= 1'b1;
        hw_request_line[3] <= 1'b1;
        repeat (10) @(posedge clock);
        chk(n_ack, nb);
        debug_freeze <= 1'b0;
        waitack(nb + 2);
        hw_request_line[3] <= 1'b0;
        chk(last_cmd.write, 1'b0);
        rchk(8'h7c, 32'h7);
        rchk(8'h60, 32'h300);
        chk(channel_irq[3], 1'b1);
        wr(8'h78, 32'h0);
        wr(8'h18, 32'h0);
        rchk(8'h7c, 32'h3);
        chk(clock_gate_en, 1'b0);
        $display("auto test done");
        summarize();
    end
endmodule : tb_top
`default_nettype wire
